// >>> rtl/swp_map.vh
// command codes, field positions, byte values and timing counts for the sector protection block
`ifndef SWP_MAP_VH
`define SWP_MAP_VH
// ---------------------------------------------------------------
// command codes on the decoded command port
// ---------------------------------------------------------------
`define SWP_CMD_LOCK_READ     4'h1
`define SWP_CMD_LOCK_SET      4'h2
`define SWP_CMD_SOLID_PROG    4'h3
`define SWP_CMD_SOLID_ERASE   4'h4
`define SWP_CMD_SOLID_READ    4'h5
`define SWP_CMD_DYN_WRITE     4'h6
`define SWP_CMD_DYN_READ      4'h7
`define SWP_CMD_GANG_LOCK     4'h8
`define SWP_CMD_GANG_UNLOCK   4'h9
`define SWP_CMD_PWD_UNLOCK    4'ha
`define SWP_CMD_UNMASK_WRITE  4'hb
// ---------------------------------------------------------------
// register fields and values
// ---------------------------------------------------------------
`define SWP_LOCK_FLAG_BIT     0
`define SWP_MODE_SOLID_BIT    1
`define SWP_MODE_PWD_BIT      2
`define SWP_BYTE_CLEAR        8'h00
`define SWP_BYTE_SET          8'hff
// ---------------------------------------------------------------
// geometry and timing
// ---------------------------------------------------------------
`define SWP_SECTOR_BITS       12
`define SWP_BLOCK_BITS        16
`define SWP_EDGE_SECTORS      16
`define SWP_UNLOCK_WAIT_NS    2000
`define SWP_CLK_PERIOD_NS     20
`define SWP_UNLOCK_WAIT_CYC   ((`SWP_UNLOCK_WAIT_NS + `SWP_CLK_PERIOD_NS - 1) / `SWP_CLK_PERIOD_NS)
`endif

// >>> rtl/swp_region_map.v
// maps a byte address onto its protection region index
`timescale 1ns/1ps
module swp_region_map #(
  parameter ADDR_W = 27,
  parameter IDX_W  = 12
) (
  input  wire [ADDR_W-1:0] addr,
  output reg  [IDX_W-1:0]  idx
);
  `include "swp_map.vh"
  localparam BLK_W = ADDR_W - `SWP_BLOCK_BITS;
  localparam [BLK_W-1:0] TOP_BLK = {BLK_W{1'b1}};

  wire [BLK_W-1:0] blk = addr[ADDR_W-1:`SWP_BLOCK_BITS];
  wire [3:0]       sec = addr[`SWP_BLOCK_BITS-1:`SWP_SECTOR_BITS];
  localparam [IDX_W-1:0] EDGE_OFS = `SWP_EDGE_SECTORS - 1;
  // block number and sector number widened to the index width on purpose
  wire [IDX_W-1:0] blk_x = {{(IDX_W-BLK_W){1'b0}}, blk};
  wire [IDX_W-1:0] sec_x = {{(IDX_W-4){1'b0}}, sec};

  // bottom sectors 0..15, middle blocks 16.., top sectors at the end
  always @* begin
    if (blk == {BLK_W{1'b0}}) begin
      idx = {{(IDX_W-4){1'b0}}, sec};
    end else if (blk == TOP_BLK) begin
      idx = blk_x + sec_x + EDGE_OFS;
    end else begin
      idx = blk_x + EDGE_OFS;
    end
  end
endmodule // swp_region_map

// >>> rtl/swp_sector_protect.v
// per-region solid and dynamic write protection with lock flag and unmask bit
`timescale 1ns/1ps
module swp_sector_protect #(
  parameter ADDR_W  = 27,
  parameter REGIONS = 2078,
  parameter IDX_W   = 12
) (
  input  wire              sys_clk,
  input  wire              rstn,
  input  wire              cmd_valid,
  input  wire [3:0]        cmd_code,
  input  wire [ADDR_W-1:0] cmd_addr,
  input  wire              cmd_data,
  input  wire              write_enable_latch,
  input  wire              password_match,
  input  wire [2:1]        mode_lock_bits,
  input  wire              protection_scheme_select,
  input  wire              op_valid,
  input  wire [ADDR_W-1:0] op_addr,
  input  wire              solid_store_ready,
  output reg  [7:0]        rd_data_q,
  output reg               rd_valid_q,
  output reg               busy_q,
  output wire              op_refused,
  output wire              solid_bits_lock_flag,
  output wire              solid_unmask_bit,
  output reg               wel_clear_q
);
  `include "swp_map.vh"
  localparam [15:0] WAIT_CYC = `SWP_UNLOCK_WAIT_CYC;
  localparam [IDX_W-1:0] LAST_IDX = REGIONS - 1;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_UNLOCK = 2'd1;
  localparam [1:0] ST_ERASE  = 2'd2;

  reg [1:0]          state_q;
  reg [15:0]         wait_q;
  reg [IDX_W-1:0]    erase_idx_q;
  reg                lock_flag_q;
  reg                unmask_q;
  reg                init_q;
  reg [REGIONS-1:0]  dyn_q;
  // stands in for the non-volatile cells; reset only models shipping state
  reg [REGIONS-1:0]  solid_q;

  wire [IDX_W-1:0] cmd_idx;
  wire [IDX_W-1:0] op_idx;

  // ---------------------------------------------------------------
  // address to region
  // ---------------------------------------------------------------
  swp_region_map #(.ADDR_W(ADDR_W), .IDX_W(IDX_W)) u_cmd_map (
    .addr (cmd_addr),
    .idx  (cmd_idx)
  );
  swp_region_map #(.ADDR_W(ADDR_W), .IDX_W(IDX_W)) u_op_map (
    .addr (op_addr),
    .idx  (op_idx)
  );

  wire solid_mode = mode_lock_bits[`SWP_MODE_PWD_BIT];
  wire adv_on     = protection_scheme_select;
  wire take       = cmd_valid && (state_q == ST_IDLE) && !busy_q;
  wire wr_ok      = take && write_enable_latch && adv_on;
  wire solid_ok   = wr_ok && lock_flag_q;

  wire is_lock_set  = (cmd_code == `SWP_CMD_LOCK_SET);
  wire is_sprog     = (cmd_code == `SWP_CMD_SOLID_PROG);
  wire is_serase    = (cmd_code == `SWP_CMD_SOLID_ERASE);
  wire is_dwrite    = (cmd_code == `SWP_CMD_DYN_WRITE);
  wire is_glock     = (cmd_code == `SWP_CMD_GANG_LOCK);
  wire is_gunlock   = (cmd_code == `SWP_CMD_GANG_UNLOCK);
  wire is_unlock    = (cmd_code == `SWP_CMD_PWD_UNLOCK);
  wire is_unmask    = (cmd_code == `SWP_CMD_UNMASK_WRITE);

  // ---------------------------------------------------------------
  // protection decision
  // ---------------------------------------------------------------
  wire solid_eff  = solid_q[op_idx] & unmask_q;
  wire region_pro = dyn_q[op_idx] | solid_eff;
  assign op_refused = op_valid && adv_on && region_pro;
  assign solid_bits_lock_flag = lock_flag_q;
  assign solid_unmask_bit     = unmask_q;

  // ---------------------------------------------------------------
  // accepted commands
  // ---------------------------------------------------------------
  wire acc_lock_set = wr_ok && is_lock_set;
  wire acc_unlock   = wr_ok && is_unlock && !solid_mode && password_match;
  wire acc_serase   = solid_ok && is_serase;
  wire acc_sprog    = solid_ok && is_sprog;
  wire acc_unmask   = wr_ok && is_unmask && solid_mode;
  wire acc_dwrite   = wr_ok && is_dwrite;
  wire acc_glock    = wr_ok && is_glock;
  wire acc_gunlock  = wr_ok && is_gunlock;

  // reads leave the host's write enable alone; only modifying codes use it up
  wire is_modify    = is_lock_set | is_unlock | is_serase | is_sprog |
                      is_unmask | is_dwrite | is_glock | is_gunlock;
  wire wel_clear_d  = wr_ok && is_modify;

  // one cell per ready cycle; the store may stall the sweep
  wire erase_step   = (state_q == ST_ERASE) && solid_store_ready;
  wire erase_last   = erase_step && (erase_idx_q == LAST_IDX);
  wire unlock_done  = (state_q == ST_UNLOCK) && (wait_q == 16'h0001);

  // ---------------------------------------------------------------
  // next-state values
  // ---------------------------------------------------------------
  reg [1:0]       state_d;
  reg             busy_d;
  reg [15:0]      wait_d;
  reg [IDX_W-1:0] erase_idx_d;
  reg             lock_flag_d;
  reg             unmask_d;

  always @* begin
    state_d = state_q;
    busy_d  = busy_q;
    if (init_q) begin
      busy_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (acc_unlock) begin
            state_d = ST_UNLOCK;
            busy_d  = 1'b1;
          end else if (acc_serase) begin
            state_d = ST_ERASE;
            busy_d  = 1'b1;
          end
        end
        ST_UNLOCK: begin
          if (unlock_done) begin
            state_d = ST_IDLE;
            busy_d  = 1'b0;
          end
        end
        ST_ERASE: begin
          if (erase_last) begin
            state_d = ST_IDLE;
            busy_d  = 1'b0;
          end
        end
        default: begin
          state_d = ST_IDLE;
          busy_d  = 1'b0;
        end
      endcase
    end
  end

  // unlock wait counter
  always @* begin
    wait_d = wait_q;
    if (!init_q && state_q == ST_IDLE && acc_unlock) begin
      wait_d = WAIT_CYC;
    end else if (state_q == ST_UNLOCK) begin
      wait_d = wait_q - 16'h0001;
    end
  end

  // erase sweep index
  always @* begin
    erase_idx_d = erase_idx_q;
    if (!init_q && state_q == ST_IDLE && acc_serase) begin
      erase_idx_d = {IDX_W{1'b0}};
    end else if (erase_step) begin
      erase_idx_d = erase_idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
    end
  end

  always @* begin
    lock_flag_d = lock_flag_q;
    if (init_q) begin
      // mode straps sampled after release, not under reset
      lock_flag_d = solid_mode;
    end else if (state_q == ST_IDLE && acc_lock_set) begin
      // no command path sets it again in solid mode
      lock_flag_d = 1'b0;
    end else if (unlock_done) begin
      lock_flag_d = 1'b1;
    end
  end

  always @* begin
    unmask_d = unmask_q;
    if (!init_q && state_q == ST_IDLE && acc_unmask) begin
      unmask_d = cmd_data;
    end
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      wait_q      <= 16'h0000;
      erase_idx_q <= {IDX_W{1'b0}};
      lock_flag_q <= 1'b0;
      unmask_q    <= 1'b1;
      init_q      <= 1'b1;
      busy_q      <= 1'b1;
      wel_clear_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      wait_q      <= wait_d;
      erase_idx_q <= erase_idx_d;
      lock_flag_q <= lock_flag_d;
      unmask_q    <= unmask_d;
      init_q      <= 1'b0;
      busy_q      <= busy_d;
      wel_clear_q <= wel_clear_d;
    end
  end

  // ---------------------------------------------------------------
  // per-region bits
  // ---------------------------------------------------------------
  wire [REGIONS-1:0] dyn_d;
  wire [REGIONS-1:0] solid_d;

  genvar g;
  generate
    for (g = 0; g < REGIONS; g = g + 1) begin : g_region
      localparam [IDX_W-1:0] GI = g;
      wire cmd_hit   = (cmd_idx == GI);
      wire erase_hit = erase_step && (erase_idx_q == GI);
      // gang commands win over a single-bit write in the same cycle
      assign dyn_d[g] = acc_glock                ? 1'b1 :
                        acc_gunlock              ? 1'b0 :
                        (acc_dwrite && cmd_hit)  ? cmd_data :
                        dyn_q[g];
      // no single-bit clear exists; only the sweep clears
      assign solid_d[g] = erase_hit              ? 1'b0 :
                          (acc_sprog && cmd_hit) ? 1'b1 :
                          solid_q[g];
    end
  endgenerate

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dyn_q   <= {REGIONS{1'b1}};
      solid_q <= {REGIONS{1'b0}};
    end else begin
      dyn_q   <= dyn_d;
      solid_q <= solid_d;
    end
  end

  // ---------------------------------------------------------------
  // read answers
  // ---------------------------------------------------------------
  reg  [7:0] rd_data_d;
  reg        rd_valid_d;
  wire       solid_at_cmd = solid_q[cmd_idx];
  wire       dyn_at_cmd   = dyn_q[cmd_idx];

  always @* begin
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    if (take) begin
      case (cmd_code)
        `SWP_CMD_LOCK_READ: begin
          rd_valid_d = 1'b1;
          rd_data_d  = {7'h00, lock_flag_q};
        end
        `SWP_CMD_SOLID_READ: begin
          rd_valid_d = 1'b1;
          rd_data_d  = solid_at_cmd ? `SWP_BYTE_SET : `SWP_BYTE_CLEAR;
        end
        `SWP_CMD_DYN_READ: begin
          rd_valid_d = 1'b1;
          rd_data_d  = dyn_at_cmd ? `SWP_BYTE_SET : `SWP_BYTE_CLEAR;
        end
        default: begin
          rd_valid_d = 1'b0;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end
endmodule // swp_sector_protect

// >>> tb/swp_prot_asserts.sv
// port-level assertions for the sector protection block
`timescale 1ns/1ps
`include "swp_map.vh"
module swp_prot_chk (
  input wire       sys_clk,
  input wire       rstn,
  input wire       cmd_valid,
  input wire [3:0] cmd_code,
  input wire       write_enable_latch,
  input wire       password_match,
  input wire [2:1] mode_lock_bits,
  input wire       protection_scheme_select,
  input wire       op_valid,
  input wire       op_refused,
  input wire       busy_q,
  input wire       rd_valid_q,
  input wire [7:0] rd_data_q,
  input wire       solid_bits_lock_flag,
  input wire       solid_unmask_bit,
  input wire       wel_clear_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  reg  [1:0] age_q;
  wire       tk = cmd_valid && !busy_q;
  wire       we = write_enable_latch && protection_scheme_select;
  wire       lk = solid_bits_lock_flag;
  wire       pw = tk && cmd_code == `SWP_CMD_PWD_UNLOCK && !mode_lock_bits[2] && !lk;
  // edges since release; keeps the reset load edge from reading as a rise
  always @(posedge sys_clk or negedge rstn)
    if (!rstn) age_q <= 2'd0;
    else if (age_q != 2'd3) age_q <= age_q + 2'd1;
  sequence erase_taken;
    tk && cmd_code == `SWP_CMD_SOLID_ERASE && we && lk;
  endsequence
  sequence erase_busy;
    busy_q [*8];
  endsequence
  AST_RESET_LOAD: assert property (
    age_q == 2'd1 |-> lk == mode_lock_bits[2] && solid_unmask_bit) else $error("bad reset load");
  AST_LOCK_READ: assert property (
    tk && cmd_code == `SWP_CMD_LOCK_READ |=> rd_valid_q && rd_data_q == {7'h00, $past(lk)})
    else $error("lock read wrong");
  AST_LOCK_SET: assert property (
    tk && cmd_code == `SWP_CMD_LOCK_SET && we |=> !lk) else $error("lock set missed");
  AST_NO_WEL: assert property (
    tk && cmd_code == `SWP_CMD_LOCK_SET && !write_enable_latch |=> $stable(lk))
    else $error("lock set without write enable");
  AST_STICKY: assert property (
    age_q != 2'd0 && mode_lock_bits[2] && !lk |=> !lk) else $error("lock flag rose");
  AST_PWD_BAD: assert property (
    pw && !password_match |=> !lk [*8]) else $error("bad password unlocked");
  AST_PWD_OK: assert property (
    pw && password_match && we |-> ##[1:120] lk) else $error("unlock missed");
  AST_ERASE_BUSY: assert property (
    erase_taken |=> erase_busy) else $error("erase not busy");
  AST_SCHEME: assert property (
    op_refused |-> op_valid && protection_scheme_select) else $error("refused off scheme");
  AST_WEL_USED: assert property (
    tk && cmd_code == `SWP_CMD_GANG_UNLOCK && we |=> wel_clear_q) else $error("wel not consumed");
  AST_WEL_READ: assert property (
    tk && cmd_code == `SWP_CMD_LOCK_READ |=> !wel_clear_q) else $error("read consumed wel");
endmodule // swp_prot_chk

bind swp_sector_protect swp_prot_chk i_chk (.sys_clk(sys_clk), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .write_enable_latch(write_enable_latch),
  .password_match(password_match), .mode_lock_bits(mode_lock_bits),
  .protection_scheme_select(protection_scheme_select), .op_valid(op_valid),
  .op_refused(op_refused), .busy_q(busy_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
  .solid_bits_lock_flag(solid_bits_lock_flag), .solid_unmask_bit(solid_unmask_bit),
  .wel_clear_q(wel_clear_q));

// >>> tb/swp_host_model.sv
// host model issuing decoded protection commands and program or erase queries
`timescale 1ns/1ps
module swp_host_model (
  input  wire        sys_clk,
  input  wire        busy_q,
  input  wire        op_refused,
  output reg         cmd_valid = 1'b0,
  output reg  [3:0]  cmd_code = 4'h0,
  output wire [26:0] cmd_addr,
  output wire        cmd_data,
  output reg         write_enable_latch = 1'b0,
  output reg         op_valid = 1'b0,
  output wire [26:0] op_addr,
  output reg         solid_store_ready = 1'b1
);
  reg        wel_on = 1'b1;
  reg        stall  = 1'b0;
  reg [26:0] a_q    = 27'h0000000;
  reg [26:0] o_q    = 27'h0000000;
  reg        d_q    = 1'b0;
  // released lines invert so a stale value never passes
  assign cmd_addr = cmd_valid ? a_q : ~a_q;
  assign cmd_data = cmd_valid ? d_q : ~d_q;
  assign op_addr  = op_valid ? o_q : ~o_q;
  always @(posedge sys_clk) solid_store_ready <= stall ? ~solid_store_ready : 1'b1;
  task issue(input [3:0] c, input [26:0] a, input d);
    begin
      while (busy_q !== 1'b0) @(posedge sys_clk);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      a_q <= a;
      d_q <= d;
      write_enable_latch <= wel_on;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      write_enable_latch <= 1'b0;
      #1;
    end
  endtask
  task query(input [26:0] a, output r);
    begin
      @(posedge sys_clk);
      op_valid <= 1'b1;
      o_q <= a;
      #1;
      r = op_refused;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      #1;
    end
  endtask
endmodule // swp_host_model

// >>> tb/swp_sector_protect_test.sv
// self-checking bench for the sector protection block
`timescale 1ns/1ps
`include "swp_map.vh"
module swp_sector_protect_test;
  reg         sys_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         password_match = 1'b0;
  reg  [2:1]  mode_lock_bits = 2'b11;
  reg         protection_scheme_select = 1'b1;
  wire        cmd_valid, cmd_data, write_enable_latch, op_valid, solid_store_ready;
  wire [3:0]  cmd_code;
  wire [26:0] cmd_addr, op_addr;
  wire [7:0]  rd_data_q;
  wire        rd_valid_q, busy_q, op_refused, solid_bits_lock_flag, solid_unmask_bit;
  wire        wel_clear_q;
  integer     n_fail = 0, num_checks = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  swp_host_model i_host (.sys_clk(sys_clk), .busy_q(busy_q), .op_refused(op_refused),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .write_enable_latch(write_enable_latch), .op_valid(op_valid), .op_addr(op_addr),
    .solid_store_ready(solid_store_ready));
  swp_sector_protect i_dut (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .write_enable_latch(write_enable_latch), .password_match(password_match),
    .mode_lock_bits(mode_lock_bits), .protection_scheme_select(protection_scheme_select),
    .op_valid(op_valid), .op_addr(op_addr), .solid_store_ready(solid_store_ready),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .busy_q(busy_q), .op_refused(op_refused),
    .solid_bits_lock_flag(solid_bits_lock_flag), .solid_unmask_bit(solid_unmask_bit),
    .wel_clear_q(wel_clear_q));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task check(input [8:0] got, input [8:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [3:0] c, input [26:0] a, input [7:0] e);
    begin
      i_host.issue(c, a, 1'b0);
      check({rd_valid_q, rd_data_q}, {1'b1, e});
    end
  endtask
  task op(input [26:0] a, input e);
    reg r;
    begin
      i_host.query(a, r);
      check({8'h00, r}, {8'h00, e});
    end
  endtask
  task do_reset(input [2:1] m);
    begin
      rstn <= 1'b0;
      mode_lock_bits <= m;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1;
    end
  endtask
  // erase sweep dominates; stall drops once the erase is issued, so it runs unstalled; ceiling leaves room for it
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  initial begin
    do_reset(2'b11);
    rd(`SWP_CMD_LOCK_READ, 27'h0, 8'h01);
    check({8'h00, solid_unmask_bit}, 9'h001);
    check({8'h00, wel_clear_q}, 9'h000);
    rd(`SWP_CMD_DYN_READ, 27'h0, `SWP_BYTE_SET);
    op(27'h0, 1'b1);
    i_host.issue(`SWP_CMD_GANG_UNLOCK, 27'h0, 1'b0);
    check({8'h00, wel_clear_q}, 9'h001);
    rd(`SWP_CMD_DYN_READ, 27'h0, `SWP_BYTE_CLEAR);
    rd(`SWP_CMD_SOLID_READ, 27'h0, `SWP_BYTE_CLEAR);
    op(27'h0, 1'b0);
    i_host.issue(`SWP_CMD_SOLID_PROG, 27'h0001000, 1'b0);
    rd(`SWP_CMD_SOLID_READ, 27'h0001000, `SWP_BYTE_SET);
    rd(`SWP_CMD_SOLID_READ, 27'h0000000, `SWP_BYTE_CLEAR);
    op(27'h0001000, 1'b1);
    i_host.issue(`SWP_CMD_DYN_WRITE, 27'h0020000, 1'b1);
    rd(`SWP_CMD_DYN_READ, 27'h0020000, `SWP_BYTE_SET);
    i_host.issue(`SWP_CMD_UNMASK_WRITE, 27'h0, 1'b0);
    op(27'h0001000, 1'b0);
    i_host.issue(`SWP_CMD_UNMASK_WRITE, 27'h0, 1'b1);
    op(27'h0001000, 1'b1);
    i_host.stall = 1'b1;
    i_host.issue(`SWP_CMD_SOLID_ERASE, 27'h0, 1'b0);
    i_host.stall = 1'b0;
    rd(`SWP_CMD_SOLID_READ, 27'h0001000, `SWP_BYTE_CLEAR);
    i_host.wel_on = 1'b0;
    i_host.issue(`SWP_CMD_SOLID_PROG, 27'h0001000, 1'b0);
    i_host.wel_on = 1'b1;
    rd(`SWP_CMD_SOLID_READ, 27'h0001000, `SWP_BYTE_CLEAR);
    i_host.issue(`SWP_CMD_LOCK_SET, 27'h0, 1'b0);
    rd(`SWP_CMD_LOCK_READ, 27'h0, 8'h00);
    i_host.issue(`SWP_CMD_SOLID_PROG, 27'h0001000, 1'b0);
    rd(`SWP_CMD_SOLID_READ, 27'h0001000, `SWP_BYTE_CLEAR);
    password_match <= 1'b1;
    i_host.issue(`SWP_CMD_PWD_UNLOCK, 27'h0, 1'b0);
    repeat (120) @(posedge sys_clk);
    rd(`SWP_CMD_LOCK_READ, 27'h0, 8'h00);
    protection_scheme_select <= 1'b0;
    op(27'h0020000, 1'b0);
    protection_scheme_select <= 1'b1;
    password_match <= 1'b0;
    do_reset(2'b01);
    rd(`SWP_CMD_LOCK_READ, 27'h0, 8'h00);
    i_host.issue(`SWP_CMD_PWD_UNLOCK, 27'h0, 1'b0);
    repeat (120) @(posedge sys_clk);
    rd(`SWP_CMD_LOCK_READ, 27'h0, 8'h00);
    password_match <= 1'b1;
    i_host.issue(`SWP_CMD_PWD_UNLOCK, 27'h0, 1'b0);
    repeat (120) @(posedge sys_clk);
    rd(`SWP_CMD_LOCK_READ, 27'h0, 8'h01);
    end_sim;
  end
endmodule // swp_sector_protect_test
